// File: homing_pkg.sv
// constants, register map and state type of the return-to-home sequencer
// Function
// - nonzero offset adds move; stop becomes home
// - zero offset: no move, home_sensor coincide
// - searched home sets command position zero
// - preset input loads configured preset position
// - mode 0 two-sensor, 1 three, 2 push
// - run speed 1 to 1000000 Hz, default 1000
// - acceleration 1 to 1000000, default 1000
// - start speed 1 to 1000000 Hz, default 500
// - signed 24-bit offset, default zero
// - start direction 0 negative, 1 positive
// - sensor_a sensor detection enable, default off
// - step timing detection enable, default off
// - home complete output set when done
// - final speed is start speed, capped 500
// - three-sensor: run speed, stop at home
// - two-sensor: move 200 steps past limit release; push: 200 steps back from stopper contact
// - fine detect needs signal; three-sensor also needs home on
package homing_pkg;
  // clock and widths
  localparam int CLK_HZ = 20_000_000;
  localparam int SPEED_W = 20;
  localparam int ACC_W = 20;
  localparam int OFS_W = 24;
  localparam int POS_W = 32;
  localparam int PHASE_W = 25;
  localparam int ADDR_W = 5;
  // register byte offsets
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] RUN_SPD_OFS = 5'h04;
  localparam logic [4:0] ACCEL_OFS = 5'h08;
  localparam logic [4:0] START_SPD_OFS = 5'h0C;
  localparam logic [4:0] HOME_OFS_OFS = 5'h10;
  localparam logic [4:0] PRESET_OFS = 5'h14;
  localparam logic [4:0] STATUS_OFS = 5'h18;
  localparam logic [4:0] POSITION_OFS = 5'h1C;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_SENSOR_A_BIT = 3;
  localparam int CTRL_TIM_BIT = 4;
  // status field positions
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_STATE_LSB = 4;
  // homing modes
  localparam logic [1:0] MODE_TWO = 2'h0;
  localparam logic [1:0] MODE_THREE = 2'h1;
  localparam logic [1:0] MODE_PUSH = 2'h2;
  // reset values
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [SPEED_W-1:0] RUN_SPD_RST = 20'h003E8;
  localparam logic [ACC_W-1:0] ACCEL_RST = 20'h003E8;
  localparam logic [SPEED_W-1:0] START_SPD_RST = 20'h001F4;
  localparam logic [OFS_W-1:0] HOME_OFS_RST = 24'h000000;
  localparam logic DIR_RST = 1'b1;
  localparam logic SENSOR_A_EN_RST = 1'b0;
  localparam logic TIM_EN_RST = 1'b0;
  localparam logic [POS_W-1:0] PRESET_RST = 32'h00000000;
  // limits and fixed counts
  localparam logic [19:0] RANGE_MIN = 20'h00001;
  localparam logic [19:0] RANGE_MAX = 20'hF4240;
  localparam logic [SPEED_W-1:0] FINAL_CAP = 20'h001F4;
  localparam logic [OFS_W-1:0] BACKOFF_STEPS = 24'h0000C8;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEEK, ST_ESCAPE, ST_BACKOFF, ST_FINE, ST_OFFSET, ST_FINISH
  } home_state_t;

  // keep a written speed or rate inside its legal range
  function automatic logic [19:0] clamp_range(input logic [31:0] v);
    if (v < 32'(RANGE_MIN)) begin
      return RANGE_MIN;
    end else if (v > 32'(RANGE_MAX)) begin
      return RANGE_MAX;
    end
    return v[19:0];
  endfunction
endpackage

// File: step_if.sv
// interface between the sequencer and its step rate generator
`timescale 1ns/1ps
`default_nettype none
interface step_if;
  logic run; // generator may emit steps
  logic [homing_pkg::SPEED_W-1:0] speed; // step rate in Hz
  logic step; // one-cycle step event
  modport gen (input run, input speed, output step);
  modport ctl (output run, output speed, input step);
endinterface
`default_nettype wire

// File: step_rate_gen.sv
// phase accumulator that turns a rate in Hz into step pulses
`timescale 1ns/1ps
`default_nettype none
module step_rate_gen (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  step_if.gen sif
);
  logic [homing_pkg::PHASE_W-1:0] phase_r; // fractional step phase
  logic [homing_pkg::PHASE_W-1:0] sum; // phase plus this cycle's rate
  logic wrap; // a full step period elapsed

  // step is combinational so a stopping sequencer gates it at once
  always_comb begin
    sum = phase_r + homing_pkg::PHASE_W'(sif.speed);
    wrap = sum >= homing_pkg::PHASE_W'(homing_pkg::CLK_HZ);
    sif.step = sif.run && wrap;
  end

  // phase restarts from zero whenever motion halts
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_r <= '0;
    end else if (!sif.run) begin
      phase_r <= '0;
    end else if (wrap) begin
      phase_r <= sum - homing_pkg::PHASE_W'(homing_pkg::CLK_HZ);
    end else begin
      phase_r <= sum;
    end
  end
endmodule
`default_nettype wire

// File: move_counter.sv
// down counter of steps left in a fixed-length move
`timescale 1ns/1ps
`default_nettype none
module move_counter (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [homing_pkg::OFS_W-1:0] count_in,
  input wire logic step_in,
  output logic zero_out
);
  logic [homing_pkg::OFS_W-1:0] left_r; // steps still to travel

  // load wins over a step in the same cycle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      left_r <= '0;
    end else if (load_in) begin
      left_r <= count_in;
    end else if (step_in && left_r != '0) begin
      left_r <= left_r - 24'h000001;
    end
  end

  assign zero_out = left_r == '0;
endmodule
`default_nettype wire

// File: return_to_home_sequencer.sv
// return-to-home sequencer with avalon-mm parameter registers
`timescale 1ns/1ps
`default_nettype none
module return_to_home_sequencer (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [homing_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // host handshake
  input wire logic home_request_in,
  input wire logic preset_request_in,
  output logic ready_out,
  output logic home_complete_out,
  // sensors
  input wire logic home_sensor_in,
  input wire logic positive_limit_sensor_in,
  input wire logic negative_limit_sensor_in,
  input wire logic stopper_contact_in,
  input wire logic sensor_a_in,
  input wire logic step_timing_signal_in,
  // motion
  output logic step_out,
  output logic dir_out,
  output logic [homing_pkg::SPEED_W-1:0] speed_out,
  output logic [homing_pkg::ACC_W-1:0] accel_out,
  output logic [homing_pkg::POS_W-1:0] position_out
);
  // parameter registers
  logic [1:0] mode_r; // homing mode
  logic [homing_pkg::SPEED_W-1:0] run_spd_r; // homing_run_speed
  logic [homing_pkg::ACC_W-1:0] accel_r; // accel/decel figure
  logic [homing_pkg::SPEED_W-1:0] start_spd_r; // homing_start_speed
  logic [homing_pkg::OFS_W-1:0] home_ofs_r; // signed home offset
  logic start_dir_r; // 1 = positive
  logic sensor_a_en_r; // sensor_a takes part
  logic tim_en_r; // step timing takes part
  logic [homing_pkg::POS_W-1:0] preset_r; // preset position
  // bus state
  logic waitreq_r; // waitrequest flop
  logic [31:0] rdata_r; // read data flop
  logic bus_req; // read or write pending
  logic bus_take; // access completes this edge
  logic [31:0] rdata_nxt; // decoded read value
  // sequencer state
  homing_pkg::home_state_t state_r; // current phase
  logic dir_r; // direction of travel
  logic ready_r; // ready flop
  logic done_r; // home complete flop
  logic req_prev_r; // last home request level
  logic preset_prev_r; // last preset request level
  logic [homing_pkg::POS_W-1:0] pos_r; // command position
  logic step_r; // registered step out
  logic [homing_pkg::SPEED_W-1:0] spd_r; // registered speed out
  // helpers
  logic [homing_pkg::SPEED_W-1:0] final_spd; // homing_final_speed
  logic start_go; // begin a return-to-home
  logic preset_go; // apply the preset position
  logic limit_ahead; // limit on the side we travel to
  logic limit_any; // either limit active
  logic fine_en; // any external signal enabled
  logic fine_hit; // enabled signals all seen
  logic found; // mechanical home reached
  logic zero_pos; // force command position to zero
  logic cnt_load; // load the move counter
  logic [homing_pkg::OFS_W-1:0] cnt_val; // value for the counter
  logic cnt_zero; // fixed-length move finished
  logic ofs_neg; // offset sign
  logic [homing_pkg::OFS_W-1:0] ofs_mag; // offset magnitude
  logic counting; // state uses the counter
  logic moving; // state emits steps
  logic [homing_pkg::SPEED_W-1:0] spd_sel; // speed for this state
  step_if sif ();
  step_rate_gen u_gen (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .sif(sif.gen)
  );
  move_counter u_cnt (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .load_in(cnt_load),
    .count_in(cnt_val),
    .step_in(sif.step),
    .zero_out(cnt_zero)
  );
  assign bus_req = avs_read_in || avs_write_in;
  assign bus_take = bus_req && !waitreq_r;
  // every access gets exactly one wait cycle, then one ready cycle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      waitreq_r <= 1'b1;
    end else if (bus_req && waitreq_r) begin
      waitreq_r <= 1'b0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end
  // read decode; unmapped or unaligned reads return zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (avs_address_in == homing_pkg::CTRL_OFS) begin
      rdata_nxt[homing_pkg::CTRL_MODE_LSB +: 2] = mode_r;
      rdata_nxt[homing_pkg::CTRL_DIR_BIT] = start_dir_r;
      rdata_nxt[homing_pkg::CTRL_SENSOR_A_BIT] = sensor_a_en_r;
      rdata_nxt[homing_pkg::CTRL_TIM_BIT] = tim_en_r;
    end else if (avs_address_in == homing_pkg::RUN_SPD_OFS) begin
      rdata_nxt = 32'(run_spd_r);
    end else if (avs_address_in == homing_pkg::ACCEL_OFS) begin
      rdata_nxt = 32'(accel_r);
    end else if (avs_address_in == homing_pkg::START_SPD_OFS) begin
      rdata_nxt = 32'(start_spd_r);
    end else if (avs_address_in == homing_pkg::HOME_OFS_OFS) begin
      rdata_nxt = 32'(signed'(home_ofs_r)); // sign extended
    end else if (avs_address_in == homing_pkg::PRESET_OFS) begin
      rdata_nxt = preset_r;
    end else if (avs_address_in == homing_pkg::STATUS_OFS) begin
      rdata_nxt[homing_pkg::STAT_READY_BIT] = ready_r;
      rdata_nxt[homing_pkg::STAT_DONE_BIT] = done_r;
      rdata_nxt[homing_pkg::STAT_BUSY_BIT] = state_r != homing_pkg::ST_IDLE;
      rdata_nxt[homing_pkg::STAT_STATE_LSB +: 3] = state_r;
    end else if (avs_address_in == homing_pkg::POSITION_OFS) begin
      rdata_nxt = pos_r;
    end
  end
  // read data captured while waitrequest is still high, so it stands
  // in the one cycle that waitrequest is low
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= 32'h00000000;
    end else if (avs_read_in && waitreq_r) begin
      rdata_r <= rdata_nxt;
    end
  end
  // parameter writes; speeds and rate are clamped into range, an
  // undefined mode code leaves the mode unchanged
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_r <= homing_pkg::MODE_RST;
      run_spd_r <= homing_pkg::RUN_SPD_RST;
      accel_r <= homing_pkg::ACCEL_RST;
      start_spd_r <= homing_pkg::START_SPD_RST;
      home_ofs_r <= homing_pkg::HOME_OFS_RST;
      start_dir_r <= homing_pkg::DIR_RST;
      sensor_a_en_r <= homing_pkg::SENSOR_A_EN_RST;
      tim_en_r <= homing_pkg::TIM_EN_RST;
      preset_r <= homing_pkg::PRESET_RST;
    end else if (bus_take && avs_write_in) begin
      if (avs_address_in == homing_pkg::CTRL_OFS) begin
        if (avs_writedata_in[homing_pkg::CTRL_MODE_LSB +: 2] != 2'h3) begin
          mode_r <= avs_writedata_in[homing_pkg::CTRL_MODE_LSB +: 2];
        end
        start_dir_r <= avs_writedata_in[homing_pkg::CTRL_DIR_BIT];
        sensor_a_en_r <= avs_writedata_in[homing_pkg::CTRL_SENSOR_A_BIT];
        tim_en_r <= avs_writedata_in[homing_pkg::CTRL_TIM_BIT];
      end else if (avs_address_in == homing_pkg::RUN_SPD_OFS) begin
        run_spd_r <= homing_pkg::clamp_range(avs_writedata_in);
      end else if (avs_address_in == homing_pkg::ACCEL_OFS) begin
        accel_r <= homing_pkg::clamp_range(avs_writedata_in);
      end else if (avs_address_in == homing_pkg::START_SPD_OFS) begin
        start_spd_r <= homing_pkg::clamp_range(avs_writedata_in);
      end else if (avs_address_in == homing_pkg::HOME_OFS_OFS) begin
        home_ofs_r <= avs_writedata_in[homing_pkg::OFS_W-1:0];
      end else if (avs_address_in == homing_pkg::PRESET_OFS) begin
        preset_r <= avs_writedata_in;
      end
    end
  end
  // final approach speed never exceeds the cap
  assign final_spd = (start_spd_r < homing_pkg::FINAL_CAP) ?
                     start_spd_r : homing_pkg::FINAL_CAP;
  // a rising request while ready starts homing; a held level cannot
  // restart it after completion because the host must drop it first
  assign start_go = home_request_in && !req_prev_r && ready_r &&
                    state_r == homing_pkg::ST_IDLE;
  assign preset_go = preset_request_in && !preset_prev_r &&
                     state_r == homing_pkg::ST_IDLE;
  assign limit_ahead = dir_r ? positive_limit_sensor_in :
                               negative_limit_sensor_in;
  assign limit_any = positive_limit_sensor_in || negative_limit_sensor_in;
  assign fine_en = sensor_a_en_r || tim_en_r;
  // with both enabled both signals must coincide
  assign fine_hit = (!sensor_a_en_r || sensor_a_in) &&
                    (!tim_en_r || step_timing_signal_in);
  assign ofs_neg = home_ofs_r[homing_pkg::OFS_W-1];
  assign ofs_mag = ofs_neg ? (~home_ofs_r + 24'h000001) : home_ofs_r;
  // mechanical home reached in this cycle
  always_comb begin
    found = 1'b0;
    if (state_r == homing_pkg::ST_SEEK && mode_r == homing_pkg::MODE_THREE &&
        home_sensor_in && !fine_en) begin
      found = 1'b1;
    end else if (state_r == homing_pkg::ST_BACKOFF && cnt_zero &&
                 !fine_en) begin
      found = 1'b1;
    end else if (state_r == homing_pkg::ST_FINE && fine_hit &&
                 (home_sensor_in || mode_r != homing_pkg::MODE_THREE)) begin
      found = 1'b1;
    end
  end
  // counter loads: 200 steps for back-off, offset for the offset move
  always_comb begin
    cnt_load = 1'b0;
    cnt_val = homing_pkg::BACKOFF_STEPS;
    if (state_r == homing_pkg::ST_ESCAPE && !limit_any) begin
      cnt_load = 1'b1;
    end else if (state_r == homing_pkg::ST_SEEK &&
                 mode_r == homing_pkg::MODE_PUSH && stopper_contact_in) begin
      cnt_load = 1'b1;
    end else if (found) begin
      cnt_load = 1'b1;
      cnt_val = ofs_mag;
    end
  end
  // speed and stepping per phase
  always_comb begin
    counting = state_r == homing_pkg::ST_BACKOFF ||
               state_r == homing_pkg::ST_OFFSET;
    moving = state_r == homing_pkg::ST_SEEK ||
             state_r == homing_pkg::ST_ESCAPE ||
             state_r == homing_pkg::ST_FINE || counting;
    if (state_r == homing_pkg::ST_SEEK && mode_r == homing_pkg::MODE_THREE) begin
      spd_sel = run_spd_r;
    end else if (state_r == homing_pkg::ST_SEEK ||
                 state_r == homing_pkg::ST_ESCAPE) begin
      spd_sel = start_spd_r;
    end else if (state_r == homing_pkg::ST_OFFSET) begin
      spd_sel = run_spd_r;
    end else begin
      spd_sel = final_spd;
    end
  end
  // a finished count gates the step at once so no extra step leaks
  assign sif.run = moving && !(counting && cnt_zero) && !cnt_load;
  assign sif.speed = spd_sel;
  // position goes to zero at mechanical home and again at the end
  assign zero_pos = found || state_r == homing_pkg::ST_FINISH;
  // homing phases
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= homing_pkg::ST_IDLE;
      dir_r <= 1'b1;
    end else begin
      case (state_r)
        homing_pkg::ST_IDLE: begin
          if (start_go) begin
            state_r <= homing_pkg::ST_SEEK;
            dir_r <= start_dir_r;
          end
        end
        homing_pkg::ST_SEEK: begin
          if (found) begin
            state_r <= (ofs_mag != '0) ? homing_pkg::ST_OFFSET :
                                         homing_pkg::ST_FINISH;
            dir_r <= !ofs_neg;
          end else if (mode_r == homing_pkg::MODE_THREE && home_sensor_in) begin
            state_r <= homing_pkg::ST_FINE;
          end else if (mode_r == homing_pkg::MODE_PUSH && stopper_contact_in) begin
            state_r <= homing_pkg::ST_BACKOFF;
            dir_r <= !dir_r;
          end else if (limit_ahead) begin
            // three-sensor turns round at a limit and keeps searching
            dir_r <= !dir_r;
            if (mode_r == homing_pkg::MODE_TWO) begin
              state_r <= homing_pkg::ST_ESCAPE;
            end
          end
        end
        homing_pkg::ST_ESCAPE: begin
          if (!limit_any) begin
            state_r <= homing_pkg::ST_BACKOFF;
          end
        end
        homing_pkg::ST_BACKOFF: begin
          if (found) begin
            state_r <= (ofs_mag != '0) ? homing_pkg::ST_OFFSET :
                                         homing_pkg::ST_FINISH;
            dir_r <= !ofs_neg;
          end else if (cnt_zero) begin
            state_r <= homing_pkg::ST_FINE; // continue for the signal
          end
        end
        homing_pkg::ST_FINE: begin
          if (found) begin
            state_r <= (ofs_mag != '0) ? homing_pkg::ST_OFFSET :
                                         homing_pkg::ST_FINISH;
            dir_r <= !ofs_neg;
          end else if (limit_ahead) begin
            dir_r <= !dir_r; // missed it, sweep back
          end
        end
        homing_pkg::ST_OFFSET: begin
          if (cnt_zero) begin
            state_r <= homing_pkg::ST_FINISH;
          end
        end
        default: begin // finish, or a stray code, returns to idle
          state_r <= homing_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // ready drops at the start and returns with completion
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_r <= 1'b1;
    end else if (start_go) begin
      ready_r <= 1'b0;
    end else if (state_r == homing_pkg::ST_FINISH) begin
      ready_r <= 1'b1;
    end
  end
  // home complete clears at the start, sets at finish or preset
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_r <= 1'b0;
    end else if (state_r == homing_pkg::ST_FINISH || preset_go) begin
      done_r <= 1'b1;
    end else if (start_go) begin
      done_r <= 1'b0;
    end
  end
  // request edge memories
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_prev_r <= 1'b0;
      preset_prev_r <= 1'b0;
    end else begin
      req_prev_r <= home_request_in;
      preset_prev_r <= preset_request_in;
    end
  end
  // command position tracks steps; zero and preset override them
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pos_r <= '0;
    end else if (zero_pos) begin
      pos_r <= '0;
    end else if (preset_go) begin
      pos_r <= preset_r;
    end else if (sif.step) begin
      pos_r <= dir_r ? pos_r + 32'h00000001 : pos_r - 32'h00000001;
    end
  end
  // motion outputs registered for clean pins
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      step_r <= 1'b0;
      spd_r <= '0;
    end else begin
      step_r <= sif.step;
      spd_r <= moving ? spd_sel : '0;
    end
  end
  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = waitreq_r;
  assign ready_out = ready_r;
  assign home_complete_out = done_r;
  assign step_out = step_r;
  assign dir_out = dir_r;
  assign speed_out = spd_r;
  assign accel_out = accel_r;
  assign position_out = pos_r;
endmodule
`default_nettype wire

// File: home_chk_sva.sv
// port checker for the return-to-home sequencer
`timescale 1ns/1ps
`default_nettype none
module home_chk (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic home_request_in,
  input wire logic ready_out,
  input wire logic home_complete_out,
  input wire logic step_out,
  input wire logic [homing_pkg::SPEED_W-1:0] speed_out,
  input wire logic [homing_pkg::ACC_W-1:0] accel_out,
  input wire logic [homing_pkg::POS_W-1:0] position_out
);
  // single clock domain, so clock and reset are given once
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wait_one_a: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("wait not 1");
  wait_pulse_a: assert property (!avs_waitrequest_out |=>
    avs_waitrequest_out) else $error("waitrequest low too long");
  ready_drop_a: assert property ($rose(home_request_in) && ready_out
    |=> !ready_out && !home_complete_out) else $error("start not taken");
  done_flag_a: assert property ($rose(ready_out) |->
    home_complete_out) else $error("ready back without complete");
  home_zero_a: assert property ($rose(ready_out) |->
    position_out == 32'h00000000) else $error("home not at zero");
  step_pulse_a: assert property (step_out |=> !step_out)
    else $error("step wider than one cycle");
  idle_still_a: assert property (ready_out && $past(ready_out) |->
    !step_out && speed_out == 20'h00000) else $error("motion while ready");
  // accel may lag its write by one cycle, hence the two-cycle antecedent
  accel_hold_a: assert property (!avs_write_in && !$past(avs_write_in)
    |=> $stable(accel_out)) else $error("accel changed without write");
endmodule
bind return_to_home_sequencer home_chk u_home_chk (.*);
`default_nettype wire

// File: host_model.sv
// host controller model driving the home request handshake
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic ref_clk_in,
  input wire logic go_in,
  input wire logic ready_in,
  output logic home_request_out
);
  // raise only while ready, drop only once ready has fallen
  initial begin
    home_request_out = 1'b0;
    forever begin
      @(posedge ref_clk_in);
      if (go_in && ready_in && !home_request_out) begin
        home_request_out <= 1'b1;
      end else if (home_request_out && !ready_in) begin
        home_request_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb_return_to_home_sequencer.sv
// self-checking bench for the return-to-home sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_return_to_home_sequencer;
  logic ref_clk_in, rst_in, rd, wr, go, preset, hs, pls, nls, stop, sa, tim;
  logic req, wreq, ready, done, step, dir;
  logic [4:0] addr;
  logic [19:0] speed, accel;
  logic [31:0] wdata, rdata, pos, v, exp_q[$];
  int error_cnt, checks, cyc, negc, seed;
  return_to_home_sequencer u_return_to_home_sequencer (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .home_request_in(req), .preset_request_in(preset), .ready_out(ready),
    .home_complete_out(done), .home_sensor_in(hs),
    .positive_limit_sensor_in(pls), .negative_limit_sensor_in(nls),
    .stopper_contact_in(stop), .sensor_a_in(sa), .step_timing_signal_in(tim),
    .step_out(step), .dir_out(dir), .speed_out(speed), .accel_out(accel),
    .position_out(pos));
  host_model u_host_model (.ref_clk_in(ref_clk_in), .go_in(go),
    .ready_in(ready), .home_request_out(req));
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task automatic cmp(input string n, input logic [31:0] e,
    input logic [31:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // monitor: reads finish at the wait-free edge, oldest note first
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (step === 1'b1 && dir === 1'b0) negc <= negc + 1;
    if (rd && wreq === 1'b0) cmp("readdata", exp_q.pop_front(), rdata);
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  // one access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_in);
    while (wreq !== 1'b0) @(posedge ref_clk_in);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge ref_clk_in); // strobes stay low across one edge
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask
  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // host start, released once the sequencer has gone busy
  task automatic home_go();
    go <= 1'b1;
    while (ready !== 1'b0) @(posedge ref_clk_in);
    go <= 1'b0;
  endtask
  initial begin
    {rd, wr, go, preset, hs, pls, nls, stop, sa, tim} = 10'h000;
    addr = 5'h00;
    wdata = 32'h00000000;
    rst_in = 1'b1;
    seed = 14220;
    do_reset();
    rd_chk(5'h00, 32'h00000005);
    rd_chk(5'h04, 32'h000003E8);
    rd_chk(5'h08, 32'h000003E8);
    rd_chk(5'h0C, 32'h000001F4);
    rd_chk(5'h10, 32'h00000000);
    rd_chk(5'h02, 32'h00000000);
    rd_chk(5'h18, 32'h00000001);
    v = $random(seed);
    bus(1'b1, 5'h14, v);
    preset <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    preset <= 1'b0;
    cmp("position", v, pos);
    bus(1'b1, 5'h04, 32'h000F4240);
    bus(1'b1, 5'h08, 32'h000007D0);
    cmp("accel", 32'h000007D0, 32'(accel));
    // three-sensor runs, without and with a small negative offset
    for (int i = 0; i < 2; i++) begin
      v = i ? -((32'($random(seed)) & 32'h00000003) + 32'h00000001) : 32'h0;
      bus(1'b1, 5'h10, v);
      rd_chk(5'h10, v);
      negc = 0;
      home_go();
      repeat (30) @(posedge ref_clk_in);
      cmp("run speed", 32'h000F4240, 32'(speed));
      hs <= 1'b1;
      while (ready !== 1'b1) @(posedge ref_clk_in);
      hs <= 1'b0;
      cmp("offset steps", -v, 32'(negc));
      cmp("complete", 32'h00000001, 32'(done));
    end
    // fine detection: below and above the 500 Hz cap
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, 5'h0C, j ? 32'h00000320 : 32'h0000012C);
      bus(1'b1, 5'h00, j ? 32'h00000015 : 32'h0000000D);
      home_go();
      hs <= 1'b1;
      repeat (30) @(posedge ref_clk_in);
      cmp("final speed", j ? 32'h1F4 : 32'h12C, 32'(speed));
      cmp("ready", 32'h00000000, 32'(ready));
      {sa, tim} <= j ? 2'b01 : 2'b10;
      while (ready !== 1'b1) @(posedge ref_clk_in);
      {hs, sa, tim} <= 3'h0;
    end
    // two-sensor and push: reverse at the positive limit or on stopper contact, then reset mid-run
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 5'h0C, 32'h000F4240);
      bus(1'b1, 5'h00, k ? 32'h00000006 : 32'h00000004);
      home_go();
      repeat (30) @(posedge ref_clk_in);
      cmp("seek speed", 32'h000F4240, 32'(speed));
      {pls, stop} <= k ? 2'b01 : 2'b10;
      repeat (30) @(posedge ref_clk_in);
      cmp("dir", 32'h00000000, 32'(dir));
      {pls, stop} <= 2'b00;
      do_reset();
    end
    summarize();
  end
endmodule
`default_nettype wire
